// file: design/irq_vec.sv
// Interrupt receive, rank, acknowledge and vector latch with APB registers
//
// Behaviour
// [RULE1] Vector register ignores software writes
// [RULE2] Vector register upper byte reads zero
// [RULE3] Acknowledged maskable request loads peripheral offset
// [RULE4] Vector register resets to zero
// [RULE5] Accept numbered, nonmaskable and trap instructions
// [RULE6] External pins: programmable polarity and priority
// [RULE7] Peripheral requests count as hardware sources
// [RULE8] Simultaneous hardware requests served by rank
// [RULE9] Software masks each maskable level
// [RULE10] Nonmaskable requests always taken
// [RULE11] Reset pin active low, nonmaskable pin programmable
// [RULE12] Vector location is twice the number
// [RULE13] Reset, reserved, nonmaskable, reserved rank fixed
// [RULE14] Six levels rank four through nine
// [RULE15] Receive, acknowledge, then execute in order
// [RULE16] Nonmaskable immediate, maskable needs enables
// [RULE17] Core fetches branch at vector location
// [RULE18] Pending flag set on latch, cleared on read
// [RULE19] Nonmaskable request goes to location 24h
// [RULE20] Latched offset held until next acknowledge
// [RULE21] Peripheral holds offset stable during acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "irq_vec_defines.svh"

module irq_vec
  import irq_vec_pkg::*;
#(
  parameter int LEVELS = 6
) (
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // External pins, asynchronous
  input  wire logic              hardware_reset_pin_n,
  input  wire logic              nmi_pin,
  input  wire logic [1:0]        ext_pin,
  // Peripheral requests per level and vector offset bus
  input  wire logic [LEVELS-1:0] periph_req,
  input  wire logic [7:0]        periph_offset,
  // Software requests from the instruction decoder
  input  wire logic              sw_req,
  input  wire sw_kind_t          sw_kind,
  input  wire logic [4:0]        sw_number,
  // Acknowledge and execution handshake with core sequencer
  output ack_t                   ack,
  input  wire logic              svc_done
);

  // ========================================================================
  // Pin synchronisers
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end else if (clk_en) begin
      sync1_reg <= {hardware_reset_pin_n, nmi_pin, ext_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // ========================================================================
  // Registers
  logic [7:0]        vec_offset_reg;
  logic              vec_pend_reg;
  logic [LEVELS-1:0] mask_reg;
  logic [4:0]        ctrl_reg;
  logic [LEVELS-1:0] level_flag_reg;
  logic              nmi_pend_reg;
  logic              rst_pend_reg;
  logic              sw_pend_reg;
  logic [4:0]        sw_num_reg;
  logic              sw_mask_intm_reg;
  logic              intm_reg;
  logic              nmi_lock_reg;
  logic              nmi_prev_reg;
  logic [LEVELS-1:0] hw_prev_reg;

  wire logic wr_en = psel && penable && pwrite && clk_en;
  wire logic rd_en = psel && penable && !pwrite && clk_en;

  // Polarity: pin is active when it differs from the polarity bit inverted
  wire logic       nmi_act = sync2_reg[2] ^ ~ctrl_reg[`CTRL_NMI_POL_BIT];          // [RULE11]
  wire logic [1:0] ext_act = sync2_reg[1:0] ^ ~ctrl_reg[`CTRL_EXT_POL_LSB +: 2];   // [RULE6]
  wire logic       rst_act = !sync2_reg[3];                                        // [RULE11]

  // External pins feed levels one and two; priority bit swaps which pin drives each level
  logic [LEVELS-1:0] hw_req;
  always_comb begin
    hw_req    = periph_req;                                                       // [RULE7]
    hw_req[0] = periph_req[0] | ext_act[0];                                       // [RULE6]
    hw_req[1] = periph_req[1] | ext_act[1];
    if (ctrl_reg[`CTRL_EXT_PRI_BIT]) begin
      hw_req[0] = periph_req[0] | ext_act[1];
      hw_req[1] = periph_req[1] | ext_act[0];
    end
  end

  // ========================================================================
  // Receive phase: sticky pending flags
  typedef enum logic [1:0] {st_idle, st_ack, st_exec} phase_t;
  phase_t phase_reg;

  logic       take;
  logic       take_mask;
  logic [4:0] take_num;
  logic [2:0] take_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_flag_reg <= '0;
      nmi_pend_reg   <= 1'b0;
      rst_pend_reg   <= 1'b0;
      nmi_prev_reg   <= 1'b0;
      hw_prev_reg    <= '0;
      sw_pend_reg    <= 1'b0;
      sw_num_reg     <= 5'h00;
      sw_mask_intm_reg <= 1'b0;
    end else if (clk_en) begin
      nmi_prev_reg <= nmi_act;
      hw_prev_reg  <= hw_req;
      // Rising edge sets a flag: a line held until its acknowledge must not pend twice
      for (int i = 0; i < LEVELS; i++) begin
        if (hw_req[i] && !hw_prev_reg[i])
          level_flag_reg[i] <= 1'b1;                          // set wins over clear [RULE15]
        else if (take && take_mask && take_lvl == 3'(i))
          level_flag_reg[i] <= 1'b0;
      end
      if (nmi_act && !nmi_prev_reg)
        nmi_pend_reg <= 1'b1;
      else if (take && take_num == `VEC_NMI)
        nmi_pend_reg <= 1'b0;
      if (rst_act)
        rst_pend_reg <= 1'b1;
      else if (take && take_num == `VEC_RESET)
        rst_pend_reg <= 1'b0;
      if (sw_req && sw_kind != sw_none && !sw_pend_reg) begin                    // [RULE5]
        sw_pend_reg <= 1'b1;
        case (sw_kind)
          sw_nmi: begin
            sw_num_reg       <= `VEC_NMI;                                        // [RULE19]
            sw_mask_intm_reg <= 1'b1;
          end
          sw_trap: begin
            sw_num_reg       <= `VEC_TRAP;
            sw_mask_intm_reg <= 1'b0;
          end
          default: begin
            sw_num_reg       <= sw_number;
            sw_mask_intm_reg <= 1'b1;
          end
        endcase
      end else if (take && !take_mask && sw_pend_reg && take_num == sw_num_reg) begin
        sw_pend_reg <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Arbitration by fixed rank
  always_comb begin
    take      = 1'b0;
    take_mask = 1'b0;
    take_num  = 5'h00;
    take_lvl  = 3'h0;
    if (phase_reg == st_idle) begin
      if (rst_pend_reg) begin                                                    // [RULE13]
        // Reset vector waits for the pin's release; nothing else is taken meanwhile
        take     = !rst_act;                                                     // [RULE11]
        take_num = `VEC_RESET;
      end else if (nmi_pend_reg && !nmi_lock_reg) begin                          // [RULE10]
        take     = 1'b1;
        take_num = `VEC_NMI;                                                     // [RULE19]
      end else if (sw_pend_reg) begin                                            // [RULE16]
        take     = 1'b1;
        take_num = sw_num_reg;
      end else if (!intm_reg && ctrl_reg[`CTRL_GIE_BIT]) begin                   // [RULE16]
        for (int i = LEVELS - 1; i >= 0; i--) begin
          if (level_flag_reg[i] && mask_reg[i]) begin                            // [RULE9]
            take      = 1'b1;
            take_mask = 1'b1;
            take_lvl  = 3'(i);
            take_num  = 5'(`VEC_LEVEL_BASE + 5'(i));                             // [RULE14] [RULE8]
          end
        end
      end
    end
  end

  // ========================================================================
  // Acknowledge and execute phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg    <= st_idle;
      ack          <= '0;
      intm_reg     <= 1'b1;
      nmi_lock_reg <= 1'b0;
    end else if (clk_en) begin
      case (phase_reg)
        st_idle: begin
          ack.valid <= 1'b0;
          if (take) begin                                                        // [RULE15]
            phase_reg    <= st_ack;
            ack.valid    <= 1'b1;
            ack.maskable <= take_mask;
            ack.number   <= take_num;
            ack.location <= {take_num, 1'b0};                                    // [RULE12] [RULE17]
            if (take_num == `VEC_NMI)
              nmi_lock_reg <= 1'b1;
            if (take_mask || take_num == `VEC_RESET || take_num == `VEC_NMI ||
                (sw_pend_reg && sw_mask_intm_reg))
              intm_reg <= 1'b1;
          end
        end
        st_ack: begin
          ack.valid <= 1'b0;
          phase_reg <= st_exec;
        end
        default: begin
          if (svc_done) begin
            phase_reg    <= st_idle;
            intm_reg     <= 1'b0;
            nmi_lock_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Vector offset latch and pending flag
  wire logic vec_rd = rd_en && paddr == `SYS_VECTOR_ADDR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_offset_reg <= 8'(`SYS_VECTOR_RESET);                                   // [RULE4]
    end else if (clk_en && take && take_mask) begin
      vec_offset_reg <= periph_offset;                                           // [RULE3] [RULE21]
    end                                                                          // [RULE20]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      vec_pend_reg <= 1'b0;
    else if (clk_en && take && take_mask)
      vec_pend_reg <= 1'b1;                                                      // [RULE18]
    else if (vec_rd)
      vec_pend_reg <= 1'b0;                                                      // [RULE18]
  end

  // ========================================================================
  // APB writes; vector register has no write path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= LEVELS'(`IRQ_MASK_RESET);
      ctrl_reg <= `IRQ_CTRL_RESET;
    end else if (wr_en) begin
      if (paddr == `IRQ_MASK_ADDR)
        mask_reg <= pwdata[LEVELS-1:0];                                          // [RULE9]
      else if (paddr == `IRQ_CTRL_ADDR)
        ctrl_reg <= pwdata[4:0];                                                 // [RULE6]
    end                                                                          // [RULE1]
  end

  // ========================================================================
  // APB read data, registered at setup so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      if (paddr == `SYS_VECTOR_ADDR)
        prdata <= {24'h00_0000, vec_offset_reg};                                 // [RULE2]
      else if (paddr == `IRQ_MASK_ADDR)
        prdata <= {26'h000_0000, mask_reg};
      else if (paddr == `IRQ_CTRL_ADDR)
        prdata <= {27'h000_0000, ctrl_reg};
      else if (paddr == `IRQ_STATUS_ADDR)
        prdata <= {16'h0000, level_flag_reg, 4'h0, intm_reg,
                   1'b0, phase_reg, ack.valid, vec_pend_reg};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Unmapped addresses answer with an error
  wire logic mapped = paddr == `SYS_VECTOR_ADDR || paddr == `IRQ_MASK_ADDR ||
                      paddr == `IRQ_CTRL_ADDR || paddr == `IRQ_STATUS_ADDR;
  assign pready  = clk_en;
  assign pslverr = psel && penable && !mapped;

endmodule : irq_vec
`default_nettype wire

// file: inc/irq_vec_defines.svh
// Offsets, field positions, reset values and vector numbers of the interrupt vectoring block
`ifndef IRQ_VEC_DEFINES_SVH
`define IRQ_VEC_DEFINES_SVH

// ==========================================================================
// Register byte addresses; the vector register's word index is its printed
// offset, so its byte address is four times that, cut to the bus width
`define SYS_VECTOR_ADDR      12'h078
`define IRQ_MASK_ADDR        12'h020
`define IRQ_CTRL_ADDR        12'h024
`define IRQ_STATUS_ADDR      12'h028
`define SW_REQ_ADDR          12'h02C
`define SYS_VECTOR_PRINTED   16'h701E

// ==========================================================================
// Field positions and reset values
`define CTRL_GIE_BIT         0
`define CTRL_NMI_POL_BIT     1
`define CTRL_EXT_POL_LSB     2
`define CTRL_EXT_PRI_BIT     4
`define STAT_VEC_PEND_BIT    0
`define STAT_ACK_BIT         1
`define SW_KIND_LSB          8
`define SYS_VECTOR_RESET     16'h0000
`define IRQ_MASK_RESET       6'h00
`define IRQ_CTRL_RESET       5'h00

// ==========================================================================
// Vector numbers
`define VEC_RESET            5'h00
`define VEC_LEVEL_BASE       5'h01
`define VEC_RSVD_LOW         5'h07
`define VEC_TRAP             5'h11
`define VEC_NMI              5'h12
`define VEC_RSVD_HIGH        5'h13

`endif

// file: inc/irq_vec_pkg.sv
// Types shared by the interrupt vectoring block
package irq_vec_pkg;

  // ========================================================================
  // Software request kinds
  typedef enum logic [1:0] {
    sw_numbered,
    sw_nmi,
    sw_trap,
    sw_none
  } sw_kind_t;

  // ========================================================================
  // Acknowledge carrier toward the core sequencer
  typedef struct packed {
    logic       valid;
    logic       maskable;
    logic [4:0] number;
    logic [5:0] location;
  } ack_t;

endpackage : irq_vec_pkg

// file: test/irq_vec_monitor.sv
// Checker of the vectoring block's port behaviour
`timescale 1ns/1ps
`default_nettype none
`include "irq_vec_defines.svh"
module irq_vec_monitor
  import irq_vec_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Requests and acknowledge
  input wire logic        sw_req,
  input wire sw_kind_t    sw_kind,
  input wire ack_t        ack,
  input wire logic        svc_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        busy_reg;
  logic        fresh_reg;
  logic [31:0] last_reg;
  wire logic   rd = psel && penable && pready && !pwrite && paddr == `SYS_VECTOR_ADDR;
  // ==========================================================
  // Service tracking; a reset-pin preempt is not modelled here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_reg <= 1'b0;
    else if (ack.valid) busy_reg <= 1'b1;
    else if (svc_done) busy_reg <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 32'h0;
      fresh_reg <= 1'b0;
    end else begin
      if (rd) last_reg <= prdata;
      if (ack.valid && ack.maskable) fresh_reg <= 1'b1;
      else if (rd) fresh_reg <= 1'b0;
    end
  end
  // ==========================================================
  // Properties
  chk_loc_twice: assert property (ack.valid |-> ack.location == {ack.number, 1'b0})
    else $error("location not twice number");
  chk_ack_pulse: assert property ($rose(ack.valid) |=> !ack.valid)
    else $error("acknowledge longer than one cycle");
  chk_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("vector upper bits set");
  chk_maskable_hw: assert property (ack.valid && ack.maskable |-> ack.number inside {[1:6]})
    else $error("maskable from non level source");
  chk_nmi_loc: assert property (ack.valid && ack.number == `VEC_NMI |-> ack.location == 6'h24 && !ack.maskable)
    else $error("nonmaskable location wrong");
  chk_sw_fast: assert property (sw_req && sw_kind != sw_none && !busy_reg |-> ##[1:8] ack.valid)
    else $error("software request not taken");
  chk_no_reentry: assert property (ack.valid |-> !busy_reg)
    else $error("acknowledge during service");
  chk_vec_hold: assert property (rd && !fresh_reg |-> prdata == last_reg)
    else $error("vector changed without acknowledge");
endmodule : irq_vec_monitor
bind irq_vec irq_vec_monitor u_irq_vec_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .sw_req(sw_req), .sw_kind(sw_kind),
  .ack(ack), .svc_done(svc_done));
`default_nettype wire

// file: test/periph_model.sv
// Peripherals and core sequencer facing the vectoring block
`timescale 1ns/1ps
`default_nettype none
module periph_model
  import irq_vec_pkg::*;
#(
  parameter logic [7:0] OFF_BASE = 8'hA0
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench control and acknowledge
  input  wire logic [5:0] raise,
  input  wire ack_t       ack,
  // Toward the block
  output logic      [5:0] periph_req,
  output logic      [7:0] periph_offset,
  output logic            svc_done
);
  logic [7:0] hold_reg;
  logic [3:0] svc_reg;
  // ==========================================================
  // Level requests stay up until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) periph_req <= 6'h00;
    else if (ack.valid && ack.maskable)
      periph_req <= (periph_req & ~(6'h01 << (ack.number - 5'h01))) | raise;
    else periph_req <= periph_req | raise;
  end
  // Lowest pending level drives; a released bus toggles so no stale value passes
  always_comb begin
    periph_offset = ~hold_reg;
    for (int i = 5; i >= 0; i--) begin
      if (periph_req[i]) periph_offset = OFF_BASE + 8'(i);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_reg <= 8'h00;
    else hold_reg <= periph_offset;
  end
  // Service routine ends a fixed while after each acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) svc_reg <= 4'h0;
    else if (ack.valid) svc_reg <= 4'hC;
    else if (svc_reg != 4'h0) svc_reg <= svc_reg - 4'h1;
  end
  assign svc_done = (svc_reg == 4'h1);
endmodule : periph_model
`default_nettype wire

// file: test/irq_vec_tb.sv
// Self-checking bench of the interrupt vectoring block
`timescale 1ns/1ps
`default_nettype none
`include "irq_vec_defines.svh"
module irq_vec_tb
  import irq_vec_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rst_pin_n = 1'b1, nmi_pin = 1'b1, sw_req = 1'b0, pready, pslverr, svc_done, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0]  raise = 6'h00, periph_req;
  logic [7:0]  periph_offset;
  logic [4:0]  sw_number = 5'h00;
  logic [1:0]  ext_pin = 2'b11;
  sw_kind_t    sw_kind = sw_none;
  ack_t        ack;
  int          errors = 0, total_checks = 0;
  always #2 pclk = ~pclk;
  // Ext pins idle high: polarity bits cleared means active low
  irq_vec u_irq_vec (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hardware_reset_pin_n(rst_pin_n), .nmi_pin(nmi_pin),
    .ext_pin(ext_pin), .periph_req(periph_req), .periph_offset(periph_offset), .sw_req(sw_req),
    .sw_kind(sw_kind), .sw_number(sw_number), .ack(ack), .svc_done(svc_done));
  periph_model u_periph_model (.pclk(pclk), .presetn(presetn), .raise(raise), .ack(ack),
    .periph_req(periph_req), .periph_offset(periph_offset), .svc_done(svc_done));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  task automatic wait_ack(input logic [4:0] num, input logic mk);
    int n;
    n = 0;
    while (ack.valid !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    check({ack.valid, ack.maskable, ack.number, ack.location}, {1'b1, mk, num, num, 1'b0});
  endtask : wait_ack
  task automatic settle;
    repeat (20) @(posedge pclk);
  endtask : settle
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    bus(1'b0, `SYS_VECTOR_ADDR, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `SYS_VECTOR_ADDR, 32'hFFFFFFFF);
    bus(1'b0, `SYS_VECTOR_ADDR, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 12'h0FC, 32'h0);
    check(serr, 1'b1);
  endtask : t_regs
  task automatic t_pin;
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    rst_pin_n <= 1'b1;
    wait_ack(`VEC_RESET, 1'b0);
    settle();
  endtask : t_pin
  task automatic t_sw;
    sw_kind_t   k [4] = '{sw_numbered, sw_numbered, sw_trap, sw_nmi};
    logic [4:0] v [4] = '{5'h1F, 5'h08, `VEC_TRAP, `VEC_NMI};
    for (int i = 0; i < 4; i++) begin
      sw_req <= 1'b1;
      sw_kind <= k[i];
      sw_number <= v[i];
      @(posedge pclk);
      sw_req <= 1'b0;
      wait_ack(v[i], 1'b0);
      settle();
    end
  endtask : t_sw
  task automatic t_nmi;
    nmi_pin <= 1'b0;
    wait_ack(`VEC_NMI, 1'b0);
    settle();
    bus(1'b1, `IRQ_CTRL_ADDR, 32'h2);
    nmi_pin <= 1'b1;
    wait_ack(`VEC_NMI, 1'b0);
    settle();
    nmi_pin <= 1'b0;
  endtask : t_nmi
  task automatic t_rank;
    bus(1'b1, `IRQ_MASK_ADDR, 32'h3F);
    bus(1'b1, `IRQ_CTRL_ADDR, 32'h3);
    raise <= 6'h03;
    @(posedge pclk);
    raise <= 6'h00;
    wait_ack(5'h01, 1'b1);
    bus(1'b0, `IRQ_STATUS_ADDR, 32'h0);
    check(rd[0], 1'b1);
    bus(1'b0, `SYS_VECTOR_ADDR, 32'h0);
    check(rd, 32'hA0);
    bus(1'b0, `IRQ_STATUS_ADDR, 32'h0);
    check(rd[0], 1'b0);
    wait_ack(5'h02, 1'b1);
    settle();
    bus(1'b0, `SYS_VECTOR_ADDR, 32'h0);
    check(rd, 32'hA1);
  endtask : t_rank
  task automatic t_mask;
    int hits;
    hits = 0;
    bus(1'b1, `IRQ_MASK_ADDR, 32'h3B);
    raise <= 6'h04;
    @(posedge pclk);
    raise <= 6'h00;
    repeat (30) begin
      @(posedge pclk);
      if (ack.valid === 1'b1) hits++;
    end
    check(hits, 0);
    bus(1'b1, `IRQ_MASK_ADDR, 32'h3F);
    wait_ack(5'h03, 1'b1);
    settle();
    bus(1'b0, `SYS_VECTOR_ADDR, 32'h0);
    check(rd, 32'hA2);
  endtask : t_mask
  task automatic t_ext;
    bus(1'b1, `IRQ_CTRL_ADDR, 32'h13);
    ext_pin <= 2'b10;
    wait_ack(5'h02, 1'b1);
    ext_pin <= 2'b11;
    settle();
    bus(1'b1, `IRQ_CTRL_ADDR, 32'h0F);
    wait_ack(5'h01, 1'b1);
    @(posedge pclk);
    wait_ack(5'h02, 1'b1);
  endtask : t_ext
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    t_regs();
    t_pin();
    t_sw();
    t_nmi();
    t_rank();
    t_mask();
    t_ext();
    summarize();
  end
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule : irq_vec_tb
`default_nettype wire
